// *** inc/ifd_defs.vh ***
// Constants for the instruction format decoder
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH
`define IFD_INSN_W        12
`define IFD_DATA_W        8
`define IFD_PC_W          10
`define IFD_FILE_W        7
`define IFD_FILE_MAX      7'h7F
`define IFD_LIT8_W        8
`define IFD_LIT9_W        9
`define IFD_PHASES        4
`define IFD_PHASE_LAST    2'h3
`define IFD_NOP_WORD      12'h000
`define IFD_DIR_FILE      3'h6
`define IFD_TIMER_ZERO_ADDR     7'h01
`define IFD_PC_FILE       7'h02
`define IFD_RESET_PC      10'h3FF
`define IFD_CLS_BYTE      2'h0
`define IFD_CLS_BIT       2'h1
`define IFD_CLS_LIT       2'h2
`define IFD_OP_NONE       4'h0
`define IFD_OP_ALU        4'h1
`define IFD_OP_BCLR       4'h2
`define IFD_OP_BSET       4'h3
`define IFD_OP_BTSC       4'h4
`define IFD_OP_BTSS       4'h5
`define IFD_OP_LITW       4'h6
`define IFD_OP_CALL       4'h7
`define IFD_OP_JUMP       4'h8
`define IFD_OP_RETLW      4'h9
`define IFD_OP_RET        4'hA
`define IFD_OP_DIR        4'hB
`define IFD_OP_SKPZ       4'hC
`define IFD_OP_MISC       4'hD
`endif

// *** rtl/ifd_field_split.v ***
// Combinational split of one instruction word into class and operand fields
`timescale 1ns/1ps
`include "ifd_defs.vh"
module ifd_field_split
(
	// Instruction word
	input  wire [11:0] insn,
	// Decoded fields
	output reg  [1:0]  cls,
	output reg  [3:0]  op,
	output wire [6:0]  file_sel,
	output wire        dest_file,
	output wire [2:0]  bit_pos,
	output wire [8:0]  lit
);
	// Bits 6:5 of f are don't-care in the five-bit encodings; driven as zero
	assign file_sel  = {2'h0, insn[4:0]}; // [RULE_06]
	assign dest_file = insn[5]; // [RULE_03]
	assign bit_pos   = insn[7:5]; // [RULE_04]
	assign lit       = (insn[11:9] == 3'h5) ? insn[8:0] : {1'h0, insn[7:0]}; // [RULE_05]

	always @*
	begin
		cls = `IFD_CLS_LIT;
		op  = `IFD_OP_NONE;
		if (insn[11:10] == 2'h0) // [RULE_02]
		begin
			cls = `IFD_CLS_BYTE;
			op  = `IFD_OP_ALU;
			if ((insn[9:6] == 4'hB) || (insn[9:6] == 4'hF))
				op = `IFD_OP_SKPZ; // [RULE_08]
			else if (insn[9:5] == 5'h00)
			begin
				cls = `IFD_CLS_LIT;
				if (insn[4:3] == 2'h0 && insn[2:0] != 3'h0)
					op = (insn[2:0] == 3'h6 || insn[2:0] == 3'h7) ? `IFD_OP_DIR : `IFD_OP_MISC;
				else if (insn[4:3] == 2'h3 && insn[2:1] == 2'h3)
					op = `IFD_OP_RET;
				else if (insn[4:0] == 5'h00)
					op = `IFD_OP_NONE;
				else
					op = `IFD_OP_MISC; // [RULE_07]
			end
		end
		else if (insn[11:10] == 2'h1)
		begin
			cls = `IFD_CLS_BIT;
			if (insn[9:8] == 2'h0)
				op = `IFD_OP_BCLR;
			else if (insn[9:8] == 2'h1)
				op = `IFD_OP_BSET;
			else if (insn[9:8] == 2'h2)
				op = `IFD_OP_BTSC;
			else
				op = `IFD_OP_BTSS;
		end
		else if (insn[11:8] == 4'h8)
			op = `IFD_OP_RETLW;
		else if (insn[11:8] == 4'h9)
			op = `IFD_OP_CALL;
		else if (insn[11:9] == 3'h5)
			op = `IFD_OP_JUMP;
		else
			op = `IFD_OP_LITW;
	end
endmodule // ifd_field_split

// *** rtl/ifd_sequencer.v ***
// Instruction fetch, decode and cycle sequencing top
`timescale 1ns/1ps
`include "ifd_defs.vh"
// Overview of operation
// [RULE_01] Every instruction is one 12-bit word: opcode plus operand fields.
// [RULE_02] Each word falls into byte, bit, or literal/control class.
// [RULE_03] Byte ops: destination 0 writes accumulator, 1 writes the file register.
// [RULE_04] Bit ops: bit field picks one of eight bits, file field picks register.
// [RULE_05] Literal ops carry an 8-bit or 9-bit constant.
// [RULE_06] File address spans 0x00 to 0x7F; the decoder only forms 0x00 to 0x1F.
// [RULE_07] Don't-care bits never change behaviour.
// [RULE_08] One cycle per instruction; true skip or PC change takes two.
// [RULE_09] One instruction cycle is four core clock periods.
// [RULE_10] After skip or PC load the fetched next word executes as no-operation.
// [RULE_11] Every PC write except the jump clears PC bit 8.
// [RULE_12] Port read-modify-write sources pin levels, not the output latch.
// [RULE_13] Direction load with file 6 copies accumulator to first port latches.
// [RULE_14] A write to timer zero clears the prescaler when assigned to it.
module ifd_sequencer
#(
	parameter PC_W = 10
)
(
	// Clock and reset
	input  wire            core_clk,
	input  wire            rst_b,
	input  wire            clk_en,
	// Program memory
	input  wire [11:0]     prog_word,
	output reg  [PC_W-1:0] prog_addr,
	// Datapath status inputs
	input  wire            alu_zero,
	input  wire [7:0]      file_rdata,
	input  wire [6:0]      port_file_sel,
	input  wire            prescale_to_timer,
	input  wire [PC_W-1:0] stack_top,
	input  wire [7:0]      acc_value,
	// Datapath controls
	output reg  [1:0]      insn_class_r,
	output reg  [3:0]      insn_op_r,
	output reg  [6:0]      file_addr_r,
	output reg  [2:0]      bit_sel_r,
	output reg  [8:0]      literal_r,
	output reg             wr_acc_r,
	output reg             wr_file_r,
	output reg             use_pins_r,
	output reg             exec_r,
	output reg  [1:0]      phase_r,
	output reg             stack_push_r,
	output reg             stack_pop_r,
	output reg             first_port_dir_we_r,
	output reg  [7:0]      first_port_dir_r,
	output reg             prescale_clr_r
);
	wire [1:0] cls;
	wire [3:0] op;
	wire [6:0] fsel;
	wire       dfile;
	wire [2:0] bpos;
	wire [8:0] lit;

	reg [11:0]     ir_r;
	reg            flush_r;
	reg [PC_W-1:0] pc_r;

	ifd_field_split u_split
	(
		.insn      (ir_r),
		.cls       (cls),
		.op        (op),
		.file_sel  (fsel),
		.dest_file (dfile),
		.bit_pos   (bpos),
		.lit       (lit)
	);

	// Bit-test outcome on the operand read in phase 3
	wire bit_val  = file_rdata[bpos]; // [RULE_04]
	wire skip_hit = ((op == `IFD_OP_BTSC) && !bit_val) ||
			((op == `IFD_OP_BTSS) && bit_val) ||
			((op == `IFD_OP_SKPZ) && alu_zero); // [RULE_08]
	wire pc_load  = (op == `IFD_OP_JUMP) || (op == `IFD_OP_CALL) ||
			(op == `IFD_OP_RETLW) || (op == `IFD_OP_RET);
	wire writes_f = ((cls == `IFD_CLS_BYTE) && dfile && (op != `IFD_OP_NONE)) ||
			(op == `IFD_OP_BCLR) || (op == `IFD_OP_BSET);
	wire pc_is_f  = writes_f && (fsel == `IFD_PC_FILE);

	// Next sequential fetch address
	function [PC_W-1:0] pc_step;
		input [PC_W-1:0] addr;
		begin
			pc_step = addr + {{(PC_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// A true skip steps once: the flush already drops the fetched word
	reg [PC_W-1:0] pc_nxt;
	always @*
	begin
		pc_nxt = pc_step(pc_r); // [RULE_10]
		if (op == `IFD_OP_JUMP)
			pc_nxt = {pc_r[PC_W-1:9], lit}; // keeps bit 8 from the literal
		else if (op == `IFD_OP_CALL)
			pc_nxt = {pc_r[PC_W-1:9], 1'b0, lit[7:0]}; // [RULE_11]
		else if (op == `IFD_OP_RETLW || op == `IFD_OP_RET)
			pc_nxt = {stack_top[PC_W-1:9], 1'b0, stack_top[7:0]}; // [RULE_11]
		else if (pc_is_f)
			pc_nxt = {pc_r[PC_W-1:9], 1'b0, acc_value}; // [RULE_11]
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phase_r             <= 2'h0;
			ir_r                <= `IFD_NOP_WORD;
			flush_r             <= 1'b1;
			pc_r                <= {PC_W{1'b1}};
			prog_addr           <= {PC_W{1'b1}};
			insn_class_r        <= `IFD_CLS_LIT;
			insn_op_r           <= `IFD_OP_NONE;
			file_addr_r         <= 7'h00;
			bit_sel_r           <= 3'h0;
			literal_r           <= 9'h000;
			wr_acc_r            <= 1'b0;
			wr_file_r           <= 1'b0;
			use_pins_r          <= 1'b0;
			exec_r              <= 1'b0;
			stack_push_r        <= 1'b0;
			stack_pop_r         <= 1'b0;
			first_port_dir_we_r <= 1'b0;
			first_port_dir_r    <= 8'hFF;
			prescale_clr_r      <= 1'b0;
		end
		else if (clk_en)
		begin
			phase_r             <= phase_r + 2'h1; // [RULE_09]
			exec_r              <= 1'b0;
			wr_acc_r            <= 1'b0;
			wr_file_r           <= 1'b0;
			stack_push_r        <= 1'b0;
			stack_pop_r         <= 1'b0;
			first_port_dir_we_r <= 1'b0;
			prescale_clr_r      <= 1'b0;
			if (phase_r == 2'h0)
			begin
				insn_class_r <= cls;
				insn_op_r    <= flush_r ? `IFD_OP_NONE : op; // [RULE_10]
				file_addr_r  <= fsel & `IFD_FILE_MAX; // [RULE_06]
				bit_sel_r    <= bpos;
				literal_r    <= lit;
				use_pins_r   <= !flush_r && writes_f && (fsel == port_file_sel); // [RULE_12]
			end
			if (phase_r == `IFD_PHASE_LAST)
			begin
				// At most one execute pulse per four clocks, none in a flushed cycle
				exec_r <= !flush_r; // [RULE_08]
				if (!flush_r)
				begin
					wr_file_r    <= writes_f; // [RULE_03]
					wr_acc_r     <= ((cls == `IFD_CLS_BYTE) && !dfile &&
							(op == `IFD_OP_ALU || op == `IFD_OP_SKPZ)) ||
							(op == `IFD_OP_LITW) || (op == `IFD_OP_RETLW); // [RULE_03]
					stack_push_r <= (op == `IFD_OP_CALL);
					stack_pop_r  <= (op == `IFD_OP_RETLW) || (op == `IFD_OP_RET);
					if ((op == `IFD_OP_DIR) && (ir_r[2:0] == `IFD_DIR_FILE))
					begin
						first_port_dir_we_r <= 1'b1; // [RULE_13]
						first_port_dir_r    <= acc_value; // [RULE_13]
					end
					prescale_clr_r <= prescale_to_timer && writes_f &&
							(fsel == `IFD_TIMER_ZERO_ADDR); // [RULE_14]
					pc_r      <= pc_nxt;
					prog_addr <= pc_nxt;
				end
				else
				begin
					pc_r      <= pc_step(pc_r);
					prog_addr <= pc_step(pc_r);
				end
				// Fetched word is discarded on a skip or branch
				flush_r <= !flush_r && (skip_hit || pc_load || pc_is_f); // [RULE_10]
				ir_r    <= prog_word; // [RULE_01]
			end
		end
	end
endmodule // ifd_sequencer

// *** tb/ifd_seq_sva.sv ***
// Checker for the instruction sequencer ports
`timescale 1ns/1ps
`include "ifd_defs.vh"
module ifd_seq_sva
#(parameter PC_W = 10)
(
	// Clock, reset and inputs
	input wire            core_clk,
	input wire            rst_b,
	input wire            clk_en,
	input wire [7:0]      acc_value,
	input wire            prescale_to_timer,
	// Sequencer outputs
	input wire [PC_W-1:0] prog_addr,
	input wire [1:0]      phase_r,
	input wire [3:0]      insn_op_r,
	input wire [6:0]      file_addr_r,
	input wire [8:0]      literal_r,
	input wire            exec_r,
	input wire            wr_acc_r,
	input wire            wr_file_r,
	input wire            stack_push_r,
	input wire            first_port_dir_we_r,
	input wire [7:0]      first_port_dir_r,
	input wire            prescale_clr_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// Three quiet phases follow every execute pulse
	sequence s_quiet;
		!exec_r [*3];
	endsequence
	a_exec_gap: assert property (exec_r |=> s_quiet)
		else $error("execute pulses closer than one instruction cycle");
	a_phase_step: assert property (clk_en |=> phase_r == $past(phase_r) + 2'h1)
		else $error("phase did not advance by one");
	a_freeze_hold: assert property (!clk_en |=> $stable(phase_r) && $stable(prog_addr))
		else $error("state moved while frozen");
	a_exec_phase: assert property (exec_r |-> phase_r == 2'h0)
		else $error("execute pulse outside phase zero");
	a_pc_hold: assert property (phase_r != 2'h0 |-> $stable(prog_addr))
		else $error("fetch address moved mid cycle");
	a_field_hold: assert property (phase_r != 2'h1 |-> $stable(literal_r) && $stable(file_addr_r))
		else $error("operand fields moved mid cycle");
	a_dest_excl: assert property (wr_acc_r |-> !wr_file_r)
		else $error("result written to both destinations");
	a_dir_load: assert property (first_port_dir_we_r |-> first_port_dir_r == acc_value)
		else $error("direction latches not loaded from accumulator");
	a_dir_keep: assert property (!first_port_dir_we_r |-> $stable(first_port_dir_r))
		else $error("direction latches changed without a load");
	a_tmr_clear: assert property (prescale_clr_r |-> file_addr_r == `IFD_TIMER_ZERO_ADDR && prescale_to_timer)
		else $error("prescaler cleared without a timer zero write");
	a_call_push: assert property (stack_push_r |-> insn_op_r == `IFD_OP_CALL && exec_r)
		else $error("stack push outside a call");
endmodule // ifd_seq_sva

// *** tb/ifd_mem_model.sv ***
// Program memory and datapath status model
`timescale 1ns/1ps
module ifd_mem_model
#(parameter PC_W = 10)
(
	// Fetch side
	input  wire [PC_W-1:0] prog_addr,
	output wire [11:0]     prog_word,
	// Datapath status
	output wire            alu_zero,
	output wire [7:0]      file_rdata
);
	reg [11:0] mem [0:(1<<PC_W)-1];
	integer i;
	initial for (i = 0; i < (1<<PC_W); i = i + 1) mem[i] = 12'h000;
	// Whole words only
	assign prog_word = mem[prog_addr];
	// Never zero, so counted skips stay untaken
	assign alu_zero = 1'b0;
	assign file_rdata = 8'h00;
endmodule // ifd_mem_model

// *** tb/tb_ifd_sequencer.sv ***
// Self-checking bench for the instruction sequencer
`timescale 1ns/1ps
`include "ifd_defs.vh"
module tb_ifd_sequencer;
	localparam PC_W = 10;
	reg             core_clk, rst_b, clk_en, prescale_to_timer;
	wire [11:0]     prog_word;
	wire [PC_W-1:0] prog_addr;
	wire            alu_zero, wr_acc_r, wr_file_r, exec_r, stack_push_r;
	wire            first_port_dir_we_r, prescale_clr_r, use_pins_r, stack_pop_r;
	wire [2:0]      bit_sel_r;
	wire [7:0]      file_rdata, first_port_dir_r;
	wire [1:0]      insn_class_r, phase_r;
	wire [3:0]      insn_op_r;
	wire [6:0]      file_addr_r;
	wire [8:0]      literal_r;
	integer         fail_count = 0, check_count = 0, dir_cnt = 0, acc_cnt = 0, n;
	ifd_mem_model #(.PC_W(PC_W)) i_ifd_mem_model (.prog_addr(prog_addr), .prog_word(prog_word),
		.alu_zero(alu_zero), .file_rdata(file_rdata));
	ifd_sequencer #(.PC_W(PC_W)) i_ifd_sequencer (.core_clk(core_clk), .rst_b(rst_b),
		.clk_en(clk_en), .prog_word(prog_word), .prog_addr(prog_addr), .alu_zero(alu_zero),
		.file_rdata(file_rdata), .port_file_sel(7'h06), .prescale_to_timer(prescale_to_timer),
		.stack_top(10'h3AB), .acc_value(8'h5A), .insn_class_r(insn_class_r),
		.insn_op_r(insn_op_r), .file_addr_r(file_addr_r), .bit_sel_r(bit_sel_r),
		.literal_r(literal_r), .wr_acc_r(wr_acc_r), .wr_file_r(wr_file_r),
		.use_pins_r(use_pins_r), .exec_r(exec_r),
		.phase_r(phase_r), .stack_push_r(stack_push_r), .stack_pop_r(stack_pop_r),
		.first_port_dir_we_r(first_port_dir_we_r), .first_port_dir_r(first_port_dir_r),
		.prescale_clr_r(prescale_clr_r));
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (first_port_dir_we_r === 1'b1) dir_cnt <= dir_cnt + 1;
	always @(posedge core_clk) if (wr_acc_r === 1'b1) acc_cnt <= acc_cnt + 1;
	task chk(input [15:0] seen, input [15:0] exp);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task tick;
	begin
		@(posedge core_clk);
		#2;
	end
	endtask
	function pick(input integer sel);
		case (sel)
			0: pick = first_port_dir_we_r;
			1: pick = stack_push_r;
			2: pick = prescale_clr_r;
			3: pick = wr_file_r;
			4: pick = stack_pop_r;
			default: pick = wr_acc_r;
		endcase
	endfunction
	// Bounded wait for a one-cycle pulse
	task wait_for(input integer sel);
	begin
		n = 0;
		tick;
		while (pick(sel) !== 1'b1 && n < 80)
		begin
			tick;
			n = n + 1;
		end
		chk(n < 80, 1);
	end
	endtask
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	initial
	begin
		#100000;
		fail_count = fail_count + 1;
		give_verdict;
	end
	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		prescale_to_timer = 1'b1;
		#1;
		// Direction load, call, flushed load, timer write, jump, two moves
		i_ifd_mem_model.mem[10'h000] = 12'h006;
		i_ifd_mem_model.mem[10'h001] = 12'h920;
		i_ifd_mem_model.mem[10'h002] = 12'h006;
		i_ifd_mem_model.mem[10'h020] = 12'h021;
		i_ifd_mem_model.mem[10'h021] = 12'hBFF;
		i_ifd_mem_model.mem[10'h022] = 12'h006;
		i_ifd_mem_model.mem[10'h1FF] = 12'h225;
		i_ifd_mem_model.mem[10'h200] = 12'h205;
		// Port move, taken bit test, skipped move, timer bit set, literal return
		i_ifd_mem_model.mem[10'h201] = 12'h226;
		i_ifd_mem_model.mem[10'h202] = 12'h665;
		i_ifd_mem_model.mem[10'h203] = 12'h205;
		i_ifd_mem_model.mem[10'h204] = 12'h561;
		i_ifd_mem_model.mem[10'h205] = 12'h811;
		repeat (16) tick;
		chk(prog_addr, 10'h3FF);
		chk(first_port_dir_r, 8'hFF);
		rst_b = 1'b1;
		$display("reset test done");
		// Freeze at phase one, away from the execute pulse
		while (phase_r !== 2'h1) tick;
		clk_en = 1'b0;
		repeat (6) tick;
		chk(phase_r, 2'h1);
		clk_en = 1'b1;
		tick;
		chk(phase_r, 2'h2);
		$display("freeze test done");
		wait_for(0);
		chk(first_port_dir_r, 8'h5A);
		$display("direction test done");
		wait_for(1);
		chk(literal_r[7:0], 8'h20);
		wait_for(2);
		chk(file_addr_r, 7'h01);
		$display("call and timer test done");
		wait_for(3);
		chk(file_addr_r, 7'h05);
		chk(wr_acc_r, 1'b0);
		chk(use_pins_r, 1'b0);
		chk(prog_addr, 10'h201);
		wait_for(5);
		chk(wr_file_r, 1'b0);
		chk(insn_class_r, `IFD_CLS_BYTE);
		chk(dir_cnt, 1);
		$display("destination test done");
		wait_for(3);
		chk(use_pins_r, 1'b1);
		chk(file_addr_r, 7'h06);
		prescale_to_timer = 1'b0;
		wait_for(3);
		chk(prescale_clr_r, 1'b0);
		chk(bit_sel_r, 3'h3);
		chk(prog_addr, 10'h206);
		chk(acc_cnt, 1);
		$display("skip test done");
		wait_for(4);
		chk(prog_addr, 10'h2AB);
		chk(literal_r, 9'h011);
		chk(wr_acc_r, 1'b1);
		$display("return test done");
		give_verdict;
	end
endmodule // tb_ifd_sequencer
bind ifd_sequencer ifd_seq_sva #(.PC_W(PC_W)) i_ifd_seq_sva (.core_clk(core_clk),
	.rst_b(rst_b), .clk_en(clk_en), .acc_value(acc_value),
	.prescale_to_timer(prescale_to_timer), .prog_addr(prog_addr), .phase_r(phase_r),
	.insn_op_r(insn_op_r), .file_addr_r(file_addr_r), .literal_r(literal_r),
	.exec_r(exec_r), .wr_acc_r(wr_acc_r), .wr_file_r(wr_file_r),
	.stack_push_r(stack_push_r), .first_port_dir_we_r(first_port_dir_we_r),
	.first_port_dir_r(first_port_dir_r), .prescale_clr_r(prescale_clr_r));
